// *** hdl/dutc_pkg.sv ***
// Constants, types and register map of the converter update timer control
// Behaviour
// - Buffering off: code writes go straight to the live code register.
// - Buffering on: writes load only the pre-buffer; live code holds.
// - Buffering on: pre-buffer goes live when counter hits zero, flag set.
// - Counter stops whenever double buffering is off, despite its enable.
// - Enabled 16-bit counter counts down once per clock from the reload.
// - At zero the counter reloads and hardware sets the request flag.
// - Output code has 10 bits; output is code times reference over 1024.
// - Software writes a 16-bit reload value used for every reload.
// - Software can read the request flag; set means a request occurred.
// - Settling choice: fast 1us and 1 MHz, slow 2.5us and 400 kHz.
// - Counter enable starts or stops counting apart from code writes.
`default_nettype none

package dutc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CODE_W = 10;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_OUTPUT_CODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'h9;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_DBUF_BIT = 0;
    localparam int CTL_CNT_EN_BIT = 1;
    localparam int CTL_SLOW_BIT = 2;
    localparam int STS_REQ_BIT = 0;
    localparam int STS_RUN_BIT = 1;
    localparam int IRQ_ZERO_BIT = 0;
    localparam int IRQ_LOAD_BIT = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] RST_CODE = 10'h000;
    localparam logic [CNT_W-1:0] RST_RELOAD = 16'h0000;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        DUTC_FAST_SETTLING,
        DUTC_SLOW_SETTLING
    } dutc_settling_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dutc_bus_req_t;

    typedef struct packed {
        logic double_buffer;
        logic counter_enable;
        dutc_settling_t settling;
    } dutc_ctrl_t;

endpackage : dutc_pkg

`default_nettype wire

// *** hdl/dutc_top.sv ***
// Converter update timer control: registers, update counter and request flag
//
// Our own choices: the strobed register port and the register offsets.
`default_nettype none

module dutc_top #(
    parameter int CODE_W = 10,
    parameter int CNT_W = 16
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire dutc_pkg::dutc_bus_req_t BUS_REQ,
    output logic [31:0] BUS_RDATA,
    output logic [CODE_W-1:0] OUTPUT_CODE,
    output logic SLOW_SETTLING,
    output logic REQUEST,
    output logic IRQ
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    dutc_pkg::dutc_ctrl_t ctrl;
    logic [CODE_W-1:0] output_code;
    logic [CODE_W-1:0] pre_buffer;
    logic [CNT_W-1:0] update_reload_value;
    logic [CNT_W-1:0] count;
    logic request_flag;
    logic [dutc_pkg::IRQ_W-1:0] irq_status;
    logic [dutc_pkg::IRQ_W-1:0] irq_enable;
    logic running;
    logic at_zero;
    logic wr_code;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_status;
    logic wr_irq_clr;
    logic wr_irq_en;
    logic live_load;
    logic [dutc_pkg::IRQ_W-1:0] irq_event;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    assign wr_code = BUS_REQ.wr
        && hit(BUS_REQ.addr, dutc_pkg::OFF_OUTPUT_CODE);
    assign wr_reload = BUS_REQ.wr && hit(BUS_REQ.addr, dutc_pkg::OFF_RELOAD);
    assign wr_ctrl = BUS_REQ.wr && hit(BUS_REQ.addr, dutc_pkg::OFF_CONTROL);
    assign wr_status = BUS_REQ.wr && hit(BUS_REQ.addr, dutc_pkg::OFF_STATUS);
    assign wr_irq_clr = BUS_REQ.wr
        && hit(BUS_REQ.addr, dutc_pkg::OFF_IRQ_CLEAR);
    assign wr_irq_en = BUS_REQ.wr
        && hit(BUS_REQ.addr, dutc_pkg::OFF_IRQ_ENABLE);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Counting needs both the enable and double buffering
    assign running = ctrl.counter_enable && ctrl.double_buffer;
    assign at_zero = running && (count == '0);

    always_ff @(posedge CLK) begin
        if (RESET) begin
            count <= dutc_pkg::RST_COUNT;
        end else if (!running) begin
            count <= update_reload_value;
        end else if (at_zero) begin
            count <= update_reload_value;
        end else begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            update_reload_value <= dutc_pkg::RST_RELOAD;
        end else if (wr_reload) begin
            update_reload_value <= BUS_REQ.wdata[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Request flag: set by zero, cleared by writing 1; set wins
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            request_flag <= 1'b0;
        end else if (at_zero) begin
            request_flag <= 1'b1;
        end else if (wr_status && BUS_REQ.wdata[dutc_pkg::STS_REQ_BIT]) begin
            request_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Output code and pre-buffer
    // ------------------------------------------------------------------
    // Copy happens on the zero that leaves the flag set
    assign live_load = at_zero && ctrl.double_buffer;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            pre_buffer <= dutc_pkg::RST_CODE;
        end else if (wr_code && ctrl.double_buffer) begin
            pre_buffer <= BUS_REQ.wdata[CODE_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            output_code <= dutc_pkg::RST_CODE;
        end else if (wr_code && !ctrl.double_buffer) begin
            output_code <= BUS_REQ.wdata[CODE_W-1:0];
        end else if (live_load) begin
            output_code <= pre_buffer;
        end
    end

    // Converter output is code * reference / 1024
    assign OUTPUT_CODE = output_code;

    // ------------------------------------------------------------------
    // Control
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl.double_buffer <= 1'b0;
            ctrl.counter_enable <= 1'b0;
            ctrl.settling <= dutc_pkg::DUTC_FAST_SETTLING;
        end else if (wr_ctrl) begin
            ctrl.double_buffer <= BUS_REQ.wdata[dutc_pkg::CTL_DBUF_BIT];
            ctrl.counter_enable <=
                BUS_REQ.wdata[dutc_pkg::CTL_CNT_EN_BIT];
            ctrl.settling <= dutc_pkg::dutc_settling_t'(
                BUS_REQ.wdata[dutc_pkg::CTL_SLOW_BIT]);
        end
    end

    assign SLOW_SETTLING =
        (ctrl.settling == dutc_pkg::DUTC_SLOW_SETTLING);

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        irq_event = '0;
        irq_event[dutc_pkg::IRQ_ZERO_BIT] = at_zero;
        irq_event[dutc_pkg::IRQ_LOAD_BIT] = live_load;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status
                & ~(wr_irq_clr ? BUS_REQ.wdata[dutc_pkg::IRQ_W-1:0] : '0))
                | irq_event;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_enable <= '0;
        end else if (wr_irq_en) begin
            irq_enable <= BUS_REQ.wdata[dutc_pkg::IRQ_W-1:0];
        end
    end

    assign IRQ = |(irq_status & irq_enable);
    assign REQUEST = request_flag;

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe, else zero
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET || !BUS_REQ.rd) begin
            BUS_RDATA <= '0;
        end else begin
            BUS_RDATA <= '0;
            case (BUS_REQ.addr)
                dutc_pkg::OFF_OUTPUT_CODE: begin
                    BUS_RDATA[CODE_W-1:0] <= ctrl.double_buffer
                        ? pre_buffer : output_code;
                end
                dutc_pkg::OFF_RELOAD: begin
                    BUS_RDATA[CNT_W-1:0] <= update_reload_value;
                end
                dutc_pkg::OFF_CONTROL: begin
                    BUS_RDATA[dutc_pkg::CTL_DBUF_BIT] <= ctrl.double_buffer;
                    BUS_RDATA[dutc_pkg::CTL_CNT_EN_BIT] <= ctrl.counter_enable;
                    BUS_RDATA[dutc_pkg::CTL_SLOW_BIT] <= SLOW_SETTLING;
                end
                dutc_pkg::OFF_STATUS: begin
                    BUS_RDATA[dutc_pkg::STS_REQ_BIT] <=
                        request_flag;
                    BUS_RDATA[dutc_pkg::STS_RUN_BIT] <= running;
                    BUS_RDATA[CNT_W+15:16] <= count;
                end
                dutc_pkg::OFF_IRQ_STATUS: begin
                    BUS_RDATA[dutc_pkg::IRQ_W-1:0] <= irq_status;
                end
                dutc_pkg::OFF_IRQ_ENABLE: begin
                    BUS_RDATA[dutc_pkg::IRQ_W-1:0] <= irq_enable;
                end
                default: begin
                    BUS_RDATA <= '0;
                end
            endcase
        end
    end

endmodule // dutc_top

`default_nettype wire

// *** sim/dutc_assertions.sv ***
// Port checker for the converter update timer control
`default_nettype none
module dutc_assertions #(
    parameter int CODE_W = 10,
    parameter int CNT_W = 16
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire dutc_pkg::dutc_bus_req_t BUS_REQ,
    input wire logic [31:0] BUS_RDATA,
    input wire logic [CODE_W-1:0] OUTPUT_CODE,
    input wire logic SLOW_SETTLING,
    input wire logic REQUEST,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Shadow of the programmed state
    // ----------------------------------------
    logic dbuf, en, slow, run, hit, wr_code, wr_ctl, wr_rel, wr_sts;
    logic [CNT_W-1:0] rel, cnt;
    logic [CODE_W-1:0] pre, wcode;
    assign wr_code = BUS_REQ.wr && BUS_REQ.addr == dutc_pkg::OFF_OUTPUT_CODE;
    assign wr_ctl = BUS_REQ.wr && BUS_REQ.addr == dutc_pkg::OFF_CONTROL;
    assign wr_rel = BUS_REQ.wr && BUS_REQ.addr == dutc_pkg::OFF_RELOAD;
    assign wr_sts = BUS_REQ.wr && BUS_REQ.addr == dutc_pkg::OFF_STATUS;
    assign wcode = BUS_REQ.wdata[CODE_W-1:0];
    assign run = dbuf && en;
    assign hit = run && cnt == '0;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            {slow, en, dbuf} <= 3'h0;
            rel <= '0;
        end else begin
            if (wr_ctl) {slow, en, dbuf} <= BUS_REQ.wdata[2:0];
            if (wr_rel) rel <= BUS_REQ.wdata[CNT_W-1:0];
        end
    end
    // Mirror of the update counter and hidden pre-buffer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pre <= '0;
            cnt <= '0;
        end else begin
            if (wr_code && dbuf) pre <= wcode;
            cnt <= (!run || hit) ? rel : cnt - 1'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    sequence s_zero;
        hit;
    endsequence
    reset_state_a: assert property (
        $past(RESET) |-> OUTPUT_CODE == '0 && !REQUEST && !SLOW_SETTLING && !IRQ)
        else $error("outputs not at reset values");
    live_write_a: assert property (
        wr_code && !dbuf |=> OUTPUT_CODE == $past(wcode))
        else $error("direct code write not applied");
    live_hold_a: assert property (
        dbuf && !hit |=> $stable(OUTPUT_CODE))
        else $error("live code changed while buffered");
    copy_live_a: assert property (
        s_zero |=> OUTPUT_CODE == $past(pre))
        else $error("pre-buffer not copied at zero");
    stop_flag_a: assert property (
        !run |=> !$rose(REQUEST))
        else $error("flag set while counter stopped");
    flag_cause_a: assert property (
        $rose(REQUEST) |-> $past(hit))
        else $error("flag set away from counter zero");
    zero_flag_a: assert property (
        s_zero |=> REQUEST)
        else $error("flag not set at counter zero");
    flag_clear_a: assert property (
        wr_sts && BUS_REQ.wdata[0] && !hit |=> !REQUEST)
        else $error("flag not cleared by software");
    settle_a: assert property (
        SLOW_SETTLING == slow)
        else $error("settling output differs from control");
endmodule // dutc_assertions

bind dutc_top dutc_assertions #(.CODE_W(CODE_W), .CNT_W(CNT_W)) u_chk (
    .CLK(CLK), .RESET(RESET), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
    .OUTPUT_CODE(OUTPUT_CODE), .SLOW_SETTLING(SLOW_SETTLING),
    .REQUEST(REQUEST), .IRQ(IRQ));

`default_nettype wire

// *** sim/dutc_tb_top.sv ***
// Self-checking bench for the converter update timer control
`default_nettype none
module dutc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic reset = 1'h1;
    dutc_pkg::dutc_bus_req_t req = '0;
    logic [31:0] rdata;
    logic [9:0] code;
    logic slow, flag, irq;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    dutc_top DUT (.CLK(clk), .RESET(reset), .BUS_REQ(req), .BUS_RDATA(rdata),
        .OUTPUT_CODE(code), .SLOW_SETTLING(slow), .REQUEST(flag), .IRQ(irq));
    initial forever #2.5 clk = ~clk;
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk) req <= '{a, d, 1'h1, 1'h0};
        @(posedge clk) req <= '0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk) req <= '{a, 32'h0, 1'h0, 1'h1};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [31:0] d;
        chk({code, slow, flag, irq}, 32'h0);
        rd(dutc_pkg::OFF_CONTROL, d);
        chk(d[2:0], 32'h0);
        $display("test reset done");
    endtask
    task automatic t_direct;
        logic [31:0] d;
        wr(dutc_pkg::OFF_OUTPUT_CODE, 32'hFFFFF5A5);
        chk(code, 32'h1A5);
        rd(dutc_pkg::OFF_OUTPUT_CODE, d);
        chk(d[9:0], 32'h1A5);
        wr(4'h3, 32'hFFFFFFFF);
        rd(4'h3, d);
        chk(d, 32'h0);
        wr(dutc_pkg::OFF_CONTROL, 32'h4);
        chk(slow, 32'h1);
        wr(dutc_pkg::OFF_CONTROL, 32'h0);
        chk(slow, 32'h0);
        $display("test direct done");
    endtask
    task automatic t_timer;
        logic [31:0] d;
        int n;
        wr(dutc_pkg::OFF_RELOAD, 32'h5);
        wr(dutc_pkg::OFF_CONTROL, 32'h1);
        wr(dutc_pkg::OFF_OUTPUT_CODE, 32'h155);
        chk(code, 32'h1A5);
        repeat (10) @(posedge clk);
        chk(flag, 32'h0);
        wr(dutc_pkg::OFF_CONTROL, 32'h2);
        repeat (10) @(posedge clk);
        chk(flag, 32'h0);
        wr(dutc_pkg::OFF_CONTROL, 32'h3);
        n = 0;
        while (flag !== 1'h1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n, 32'h6);
        chk(code, 32'h155);
        wr(dutc_pkg::OFF_OUTPUT_CODE, 32'h2AA);
        chk(code, 32'h155);
        repeat (5) @(posedge clk);
        #1 chk(code, 32'h2AA);
        wr(dutc_pkg::OFF_CONTROL, 32'h1);
        rd(dutc_pkg::OFF_STATUS, d);
        chk(d[0], 32'h1);
        wr(dutc_pkg::OFF_STATUS, 32'h1);
        chk(flag, 32'h0);
        wr(dutc_pkg::OFF_IRQ_ENABLE, 32'h1);
        chk(irq, 32'h1);
        wr(dutc_pkg::OFF_IRQ_ENABLE, 32'h0);
        chk(irq, 32'h0);
        wr(dutc_pkg::OFF_IRQ_ENABLE, 32'h1);
        wr(dutc_pkg::OFF_IRQ_CLEAR, 32'h3);
        chk(irq, 32'h0);
        $display("test timer done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        #1;
        t_reset();
        t_direct();
        t_timer();
        finish_test();
    end
endmodule // dutc_tb_top
`default_nettype wire
